// [rtl/acs_pkg.sv]
// Purpose: shared constants and types for the a/d conversion sequencer
// Assumes: 32-bit ahb-lite register bus, 100 MHz system clock
// Notes: register offsets are byte addresses of aligned words

package acs_pkg;

  // ************************************************************
  // register map
  // ************************************************************
  localparam logic [7:0] ACS_OFS_CTRL = 8'h00;    // mode, source, channel, start
  localparam logic [7:0] ACS_OFS_TIMING = 8'h04;  // conversion timing config
  localparam logic [7:0] ACS_OFS_RESULT = 8'h08;  // result register
  localparam logic [7:0] ACS_OFS_STATUS = 8'h0c;  // sticky events, write one to clear
  localparam logic [7:0] ACS_OFS_MASK = 8'h10;    // interrupt mask
  localparam logic [7:0] ACS_OFS_STATE = 8'h14;   // busy flag

  // ************************************************************
  // field positions
  // ************************************************************
  localparam int ACS_CTRL_START = 0;    // software start bit
  localparam int ACS_CTRL_CONT = 1;     // continuous mode bit
  localparam int ACS_CTRL_SRC = 2;      // start source select
  localparam int ACS_CTRL_CH_LO = 4;    // channel select, 3 bits
  localparam int ACS_TIM_CLK_LO = 0;    // conv clock select, 3 bits
  localparam int ACS_TIM_SMP_LO = 4;    // sample time select, 3 bits
  localparam int ACS_RES_CH_LO = 8;     // converted channel in result
  localparam int ACS_EV_DONE = 0;       // conversion done event
  localparam int ACS_EV_OVERRUN = 1;    // result rewritten before done cleared

  // ************************************************************
  // reset values and timing
  // ************************************************************
  localparam logic [2:0] ACS_CLK_SEL_RST = 3'h0;   // divide by 32
  localparam logic [2:0] ACS_SMP_SEL_RST = 3'h0;   // two converter clocks
  localparam logic [5:0] ACS_DIV_MAX = 6'h20;      // divider for code 000
  localparam logic [5:0] ACS_DIV_STEP = 6'h04;     // divider step per code
  localparam logic [4:0] ACS_SMP_STEP = 5'h02;     // sample periods per code
  localparam logic [1:0] ACS_SYS_SETUP = 2'h2;     // system clocks before sampling
  localparam logic [3:0] ACS_CONV_PERIODS = 4'h8;  // converter clocks of approximation
  localparam logic [2:0] ACS_IRQ_CLOCKS = 3'h2;    // done pulse length
  localparam logic [2:0] ACS_NUM_CH = 3'h5;        // analog inputs

  // ************************************************************
  // types
  // ************************************************************
  typedef enum logic [1:0] {
    ACS_IDLE = 2'b00,
    ACS_SETUP = 2'b01,
    ACS_SAMPLE = 2'b11,
    ACS_CONVERT = 2'b10
  } acs_state_e;

  typedef struct packed {
    logic [2:0] channel;  // converted channel
    logic [7:0] data;     // conversion code
  } acs_result_s;

  typedef struct packed {
    logic htrans1;       // htrans[1]: active transfer
    logic hwrite;        // write access
    logic [7:0] haddr;   // low address bits
  } acs_addr_s;

endpackage : acs_pkg

// [rtl/acs_sequencer.sv]
// Purpose: conversion sequencing for an 8-bit successive-approximation a/d converter
// Assumes: analog front end answers a sample strobe with a comparator bit per trial
// Notes: registers on ahb-lite, zero wait states, always OKAY
//
// Design decisions made here: register access over AHB-Lite and the address map.

`timescale 1ns/1ns

module acs_sequencer
  import acs_pkg::*;
(
  input wire logic sys_clk,                   // system clock, 100 MHz
  input wire logic rst_n,                     // synchronous reset, active low
  input wire logic hsel,                      // ahb slave select
  input wire logic [31:0] haddr,              // ahb address
  input wire logic [1:0] htrans,              // ahb transfer type
  input wire logic hwrite,                    // ahb write
  input wire logic [2:0] hsize,               // ahb size, words only
  input wire logic [31:0] hwdata,             // ahb write data
  input wire logic hready,                    // ahb bus ready
  output logic [31:0] hrdata,                 // ahb read data
  output logic hreadyout,                     // ahb slave ready
  output logic hresp,                         // ahb response, always okay
  input wire logic timer13_period_match,      // timer period-match trigger, pin
  input wire logic comp_bit,                  // comparator decision, pin
  output logic [2:0] mux_channel,             // analog mux selection
  output logic sample_hold,                   // track while high
  output logic [7:0] dac_code,                // trial code to capacitor array
  output logic conv_busy_flag,                // conversion in progress
  output logic conv_done_irq,                 // two-clock done pulse
  output logic irq                            // level interrupt, unmasked events
);
  import acs_pkg::*;

  // ************************************************************
  // input synchronisers
  // ************************************************************
  logic trigMeta, trigSync, trigPrev, compMeta, compSync;

  // pins come from outside the clock domain, two flops each
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      trigMeta <= 1'b0;
      trigSync <= 1'b0;
      trigPrev <= 1'b0;
      compMeta <= 1'b0;
      compSync <= 1'b0;
    end else begin
      trigMeta <= timer13_period_match;
      trigSync <= trigMeta;
      trigPrev <= trigSync;
      compMeta <= comp_bit;
      compSync <= compMeta;
    end
  end

  // edge so a long trigger level counts as one request
  logic hwTrigger;
  assign hwTrigger = trigSync & ~trigPrev;

  // ************************************************************
  // ahb-lite slave
  // ************************************************************
  acs_addr_s addrPh;
  logic wrPend;
  logic accept;
  assign accept = hsel & hready & htrans[1];
  assign wrPend = addrPh.htrans1 & addrPh.hwrite;

  // address phase captured for the following data phase
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      addrPh <= '0;
    end else if (hready) begin
      addrPh <= '{htrans1: accept, hwrite: hwrite, haddr: haddr[7:0]};
    end
  end

  logic wrCtrl, wrTiming, wrStatus, wrMask;
  // write decode, unmapped writes are dropped
  always_comb begin
    wrCtrl = 1'b0;
    wrTiming = 1'b0;
    wrStatus = 1'b0;
    wrMask = 1'b0;
    if (wrPend && addrPh.haddr == ACS_OFS_CTRL) begin
      wrCtrl = 1'b1;
    end else if (wrPend && addrPh.haddr == ACS_OFS_TIMING) begin
      wrTiming = 1'b1;
    end else if (wrPend && addrPh.haddr == ACS_OFS_STATUS) begin
      wrStatus = 1'b1;
    end else if (wrPend && addrPh.haddr == ACS_OFS_MASK) begin
      wrMask = 1'b1;
    end
  end

  // ************************************************************
  // control registers
  // ************************************************************
  logic swStart, contMode, srcSelect;
  logic [2:0] channelSelect, convClockSelect, sampleTimeSelect;
  logic [1:0] evMask;
  logic startTaken;

  // start bit: hardware clear on an accepted software-source start beats a same-cycle write
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      swStart <= 1'b0;
      contMode <= 1'b0;
      srcSelect <= 1'b0;
      channelSelect <= 3'h0;
    end else begin
      if (wrCtrl) begin
        contMode <= hwdata[ACS_CTRL_CONT];
        srcSelect <= hwdata[ACS_CTRL_SRC];
        // out-of-range channels are refused, old selection kept
        if (hwdata[ACS_CTRL_CH_LO +: 3] < ACS_NUM_CH) begin
          channelSelect <= hwdata[ACS_CTRL_CH_LO +: 3];
        end
      end
      if (startTaken && !srcSelect) begin
        swStart <= 1'b0;
      end else if (wrCtrl && hwdata[ACS_CTRL_START]) begin
        swStart <= 1'b1;
      end
    end
  end

  // timing configuration and interrupt mask
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      convClockSelect <= ACS_CLK_SEL_RST;
      sampleTimeSelect <= ACS_SMP_SEL_RST;
      evMask <= 2'h0;
    end else begin
      if (wrTiming) begin
        convClockSelect <= hwdata[ACS_TIM_CLK_LO +: 3];
        sampleTimeSelect <= hwdata[ACS_TIM_SMP_LO +: 3];
      end
      if (wrMask) begin
        evMask <= hwdata[1:0];
      end
    end
  end

  // ************************************************************
  // converter clock divider
  // ************************************************************
  logic [5:0] divLimit, divCount;
  logic adcTick, divRun;
  assign divLimit = ACS_DIV_MAX - 6'(convClockSelect * ACS_DIV_STEP);
  // tick on the last system clock of each period; >= survives a code change mid-run
  assign adcTick = divRun && (divCount >= divLimit - 6'h1);

  // divider restarts with each conversion so periods are whole
  always_ff @(posedge sys_clk) begin
    if (!rst_n || !divRun) begin
      divCount <= 6'h0;
    end else if (adcTick) begin
      divCount <= 6'h0;
    end else begin
      divCount <= divCount + 6'h1;
    end
  end

  // ************************************************************
  // sequencer
  // ************************************************************
  acs_state_e state;
  logic [4:0] phaseCount;
  logic [7:0] sarReg;
  logic [2:0] irqCount;
  logic doneEv;
  logic startReq;
  logic [4:0] sampleLimit;

  assign sampleLimit = 5'(sampleTimeSelect * ACS_SMP_STEP) + ACS_SMP_STEP;
  assign divRun = (state == ACS_SAMPLE) || (state == ACS_CONVERT);

  // source gating: the unselected source is ignored entirely
  always_comb begin
    if (srcSelect) begin
      startReq = hwTrigger;
    end else begin
      startReq = swStart;
    end
  end

  // only an idle sequencer takes a request; repeats come from continuous mode
  assign startTaken = (state == ACS_IDLE) && startReq;

  // conversion flow: setup, sample, eight approximation steps
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      state <= ACS_IDLE;
      phaseCount <= 5'h0;
      sarReg <= 8'h0;
      mux_channel <= 3'h0;
      sample_hold <= 1'b0;
      dac_code <= 8'h0;
      conv_busy_flag <= 1'b0;
      doneEv <= 1'b0;
    end else begin
      doneEv <= 1'b0;
      case (state)
        ACS_IDLE: begin
          if (startTaken) begin
            state <= ACS_SETUP;
            mux_channel <= channelSelect;
            conv_busy_flag <= 1'b1;
            phaseCount <= 5'h0;
          end
        end
        ACS_SETUP: begin
          // two system clocks after the start edge
          if (phaseCount == 5'(ACS_SYS_SETUP) - 5'h1) begin
            state <= ACS_SAMPLE;
            sample_hold <= 1'b1;
            phaseCount <= 5'h0;
          end else begin
            // channel reloaded here, one edge after done, so the result keeps the old tag
            mux_channel <= channelSelect;
            phaseCount <= phaseCount + 5'h1;
          end
        end
        ACS_SAMPLE: begin
          if (adcTick) begin
            if (phaseCount == sampleLimit - 5'h1) begin
              state <= ACS_CONVERT;
              sample_hold <= 1'b0;
              phaseCount <= 5'h0;
              sarReg <= 8'h80;
              dac_code <= 8'h80;
            end else begin
              phaseCount <= phaseCount + 5'h1;
            end
          end
        end
        ACS_CONVERT: begin
          // one bit decided per converter clock, msb first
          if (adcTick) begin
            logic [7:0] trialBit;
            logic [7:0] kept;
            trialBit = 8'h80 >> phaseCount[2:0];
            kept = compSync ? sarReg : (sarReg & ~trialBit);
            if (phaseCount == 5'(ACS_CONV_PERIODS) - 5'h1) begin
              sarReg <= kept;
              dac_code <= 8'h0;
              doneEv <= 1'b1;
              phaseCount <= 5'h0;
              if (contMode) begin
                // next pass picks up any new channel selection
                state <= ACS_SETUP;
              end else begin
                state <= ACS_IDLE;
                conv_busy_flag <= 1'b0;
              end
            end else begin
              sarReg <= kept | (trialBit >> 1);
              dac_code <= kept | (trialBit >> 1);
              phaseCount <= phaseCount + 5'h1;
            end
          end
        end
        default: begin
          state <= ACS_IDLE;
        end
      endcase
    end
  end

  // ************************************************************
  // result and done pulse
  // ************************************************************
  acs_result_s result;
  logic [1:0] evStatus;

  // result tagged with the channel it came from
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      result <= '0;
    end else if (doneEv) begin
      result <= '{channel: mux_channel, data: sarReg};
    end
  end

  // done pulse held two clocks for every conversion
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      irqCount <= 3'h0;
      conv_done_irq <= 1'b0;
    end else if (doneEv) begin
      irqCount <= ACS_IRQ_CLOCKS - 3'h1;
      conv_done_irq <= 1'b1;
    end else if (irqCount != 3'h0) begin
      irqCount <= irqCount - 3'h1;
    end else begin
      conv_done_irq <= 1'b0;
    end
  end

  // sticky events: a new event wins over a same-cycle clear
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      evStatus <= 2'h0;
    end else begin
      for (int i = 0; i < 2; i++) begin
        logic setBit;
        setBit = (i == ACS_EV_DONE) ? doneEv : (doneEv & evStatus[ACS_EV_DONE]);
        if (setBit) begin
          evStatus[i] <= 1'b1;
        end else if (wrStatus && hwdata[i]) begin
          evStatus[i] <= 1'b0;
        end
      end
    end
  end

  // level interrupt from registered status and mask
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      irq <= 1'b0;
    end else begin
      irq <= |(evStatus & evMask);
    end
  end

  // ************************************************************
  // read path
  // ************************************************************
  logic [31:0] next_hrdata;

  // read decode, unmapped addresses read zero
  always_comb begin
    next_hrdata = 32'h0;
    if (haddr[7:0] == ACS_OFS_CTRL) begin
      next_hrdata[ACS_CTRL_START] = swStart;
      next_hrdata[ACS_CTRL_CONT] = contMode;
      next_hrdata[ACS_CTRL_SRC] = srcSelect;
      next_hrdata[ACS_CTRL_CH_LO +: 3] = channelSelect;
    end else if (haddr[7:0] == ACS_OFS_TIMING) begin
      next_hrdata[ACS_TIM_CLK_LO +: 3] = convClockSelect;
      next_hrdata[ACS_TIM_SMP_LO +: 3] = sampleTimeSelect;
    end else if (haddr[7:0] == ACS_OFS_RESULT) begin
      next_hrdata[7:0] = result.data;
      next_hrdata[ACS_RES_CH_LO +: 3] = result.channel;
    end else if (haddr[7:0] == ACS_OFS_STATUS) begin
      next_hrdata[1:0] = evStatus;
    end else if (haddr[7:0] == ACS_OFS_MASK) begin
      next_hrdata[1:0] = evMask;
    end else if (haddr[7:0] == ACS_OFS_STATE) begin
      next_hrdata[0] = conv_busy_flag;
    end
  end

  // read data registered at the address phase so it stands through the data phase;
  // limitation: a read pipelined right behind a write sees the value before that write
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      hrdata <= 32'h0;
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end else begin
      hreadyout <= 1'b1;
      hresp <= 1'b0;
      if (accept && !hwrite) begin
        hrdata <= next_hrdata;
      end else begin
        hrdata <= 32'h0;
      end
    end
  end

endmodule // acs_sequencer

// [dv/acs_sequencer_checker.sv]
// Purpose: port checker for the conversion sequencer
// Assumes: one clock domain, synchronous active-low reset
// Notes: bound to every acs_sequencer instance
`timescale 1ns/1ns
module acs_sequencer_checker (
  input wire logic sys_clk,            // system clock
  input wire logic rst_n,              // reset, active low
  input wire logic hreadyout,          // slave ready
  input wire logic hresp,              // slave response
  input wire logic [2:0] mux_channel,  // mux select
  input wire logic sample_hold,        // track while high
  input wire logic conv_busy_flag,     // busy level
  input wire logic conv_done_irq       // done pulse
);
  // ************************************************************
  // properties
  // ************************************************************
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  // pulse tail and setup gap are multi-step, so named once
  sequence s_pulse_tail;
    conv_done_irq ##1 !conv_done_irq;
  endsequence
  sequence s_setup_gap;
    !sample_hold ##1 !sample_hold;
  endsequence
  a_bus_okay: assert property (hreadyout && !hresp)
    else $error("bus not ready or not okay");
  a_irq_two_clocks: assert property ($rose(conv_done_irq) |=> s_pulse_tail)
    else $error("done pulse not two clocks");
  a_setup_two_clocks: assert property ($rose(conv_busy_flag) |-> s_setup_gap)
    else $error("sampling began before setup");
  a_sample_busy: assert property (sample_hold |-> conv_busy_flag)
    else $error("sampling while idle");
  a_sample_min: assert property ($rose(sample_hold) |-> sample_hold [*8])
    else $error("sample window too short");
  a_mux_steady: assert property (sample_hold && $past(sample_hold) |-> $stable(mux_channel))
    else $error("channel moved while sampling");
  a_channel_range: assert property (conv_busy_flag |-> mux_channel < 3'h5)
    else $error("channel out of range");
  a_convert_quiet: assert property ($fell(sample_hold) |-> !conv_done_irq [*8])
    else $error("done too soon after sampling");
  a_done_window: assert property ($fell(sample_hold) |-> ##[30:262] $rose(conv_done_irq))
    else $error("conversion did not finish in time");
  a_done_clean: assert property ($rose(conv_done_irq) |-> !sample_hold && $past(conv_busy_flag, 2))
    else $error("done while sampling or idle");
endmodule // acs_sequencer_checker

bind acs_sequencer acs_sequencer_checker u_chk (.sys_clk(sys_clk), .rst_n(rst_n),
  .hreadyout(hreadyout), .hresp(hresp), .mux_channel(mux_channel),
  .sample_hold(sample_hold), .conv_busy_flag(conv_busy_flag), .conv_done_irq(conv_done_irq));

// [dv/acs_analog_model.sv]
// Purpose: analog front end stand-in, five fixed input levels and a comparator
// Assumes: comp_bit high keeps the trial bit, held level at or above the trial code
// Notes: fixed levels make every result predictable
`timescale 1ns/1ns
module acs_analog_model (
  input wire logic sys_clk,            // system clock
  input wire logic [2:0] mux_channel,  // selected input
  input wire logic sample_hold,        // track while high
  input wire logic [7:0] dac_code,     // trial code
  output logic comp_bit                // comparator decision
);
  // ************************************************************
  // hold capacitor and comparator
  // ************************************************************
  logic [7:0] held = 8'h00;
  // tracks only while sampling, so a late channel change cannot leak in
  always @(posedge sys_clk) begin
    if (sample_hold) begin
      held <= (mux_channel < 3'h5) ? 8'h1d + 8'h31 * {5'h0, mux_channel} : 8'h00;
    end
  end
  assign comp_bit = (held >= dac_code);
endmodule // acs_analog_model

// [dv/acs_sequencer_tb.sv]
// Purpose: self-checking bench for the conversion sequencer
// Assumes: zero-wait slave, read data stands in the data phase
// Notes: analog levels come from acs_analog_model
`timescale 1ns/1ns
module acs_sequencer_tb;
  import acs_pkg::*;
  // ************************************************************
  // signals, design and partner
  // ************************************************************
  logic sysClk, rstN, hsel, hwrite, trig, doneQ;
  logic hreadyout, hresp, compBit, sampleHold, convBusyFlag, convDoneIrq, irq;
  logic [31:0] haddr, hwdata, hrdata, rdv;
  logic [1:0] htrans;
  logic [2:0] hsize, muxChannel;
  logic [7:0] dacCode;
  int errors, n_tests, cyc, nDone, smp, bsy, n;
  acs_sequencer DUT (.sys_clk(sysClk), .rst_n(rstN), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .timer13_period_match(trig),
    .comp_bit(compBit), .mux_channel(muxChannel), .sample_hold(sampleHold),
    .dac_code(dacCode), .conv_busy_flag(convBusyFlag), .conv_done_irq(convDoneIrq), .irq(irq));
  acs_analog_model u_ana (.sys_clk(sysClk), .mux_channel(muxChannel),
    .sample_hold(sampleHold), .dac_code(dacCode), .comp_bit(compBit));
  // clock, 10 ns period
  initial begin
    sysClk = 1'b0;
    forever #5 sysClk = ~sysClk;
  end
  // hang guard and done-pulse counter
  always @(posedge sysClk) begin
    cyc <= cyc + 1;
    doneQ <= convDoneIrq;
    if (convDoneIrq === 1'b1 && doneQ === 1'b0) nDone <= nDone + 1;
    if (cyc == 20000) begin
      errors++;
      end_sim();
    end
  end
  task automatic end_sim;
    if (errors == 0 && n_tests > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] seen, input logic [31:0] want);
    n_tests++;
    if (seen !== want) begin
      errors++;
      $display("unexpected at %0t: got %h want %h", $time, seen, want);
    end
  endtask
  // one single word transfer; read data taken at the data phase edge
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
    hsel <= 1'b1;
    hwrite <= w;
    haddr <= {24'h0, a};
    htrans <= 2'h2;
    @(posedge sysClk);
    while (hreadyout !== 1'b1) @(posedge sysClk);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    @(posedge sysClk);
    while (hreadyout !== 1'b1) @(posedge sysClk);
    rdv = hrdata;
  endtask
  function automatic logic [7:0] lvl(input int ch);
    return 8'h1d + 8'h31 * 8'(ch);
  endfunction
  task automatic pulse;
    trig <= 1'b1;
    repeat (3) @(posedge sysClk);
    trig <= 1'b0;
    @(posedge sysClk);
  endtask
  task automatic wait_done(input int k);
    int t;
    t = nDone + k;
    while (nDone < t) @(posedge sysClk);
  endtask
  // start by software and time the whole conversion
  task automatic conv(input logic [31:0] ctl, input int s, input int d);
    xfer(1'b1, ACS_OFS_CTRL, ctl);
    smp = 0;
    bsy = 0;
    while (convDoneIrq !== 1'b1) begin
      @(posedge sysClk);
      smp += int'(sampleHold === 1'b1);
      bsy += int'(convBusyFlag === 1'b1);
    end
    repeat (3) @(posedge sysClk);
    chk(smp, (2 + 2 * s) * d);
    chk(bsy, 2 + (2 + 2 * s) * d + 8 * d);
  endtask
  // ************************************************************
  // scenarios
  // ************************************************************
  initial begin
    rstN = 1'b0;
    hsel = 1'b0;
    hwrite = 1'b0;
    haddr = 32'h0;
    htrans = 2'h0;
    hsize = 3'h2;
    hwdata = 32'h0;
    trig = 1'b0;
    repeat (5) @(posedge sysClk);
    rstN <= 1'b1;
    @(posedge sysClk);
    xfer(1'b0, ACS_OFS_CTRL, 32'h0);
    chk(rdv, 32'h0);
    xfer(1'b0, ACS_OFS_TIMING, 32'h0);
    chk(rdv, 32'h0);
    // default timing on channel 2, single mode stays idle after
    conv(32'h21, 0, 32);
    n = nDone;
    repeat (40) @(posedge sysClk);
    chk({convBusyFlag, 31'(nDone - n)}, 32'h0);
    xfer(1'b0, ACS_OFS_RESULT, 32'h0);
    chk(rdv, {21'h0, 3'h2, lvl(2)});
    xfer(1'b0, ACS_OFS_CTRL, 32'h0);
    chk(rdv[0], 1'b0);
    // sticky event, masked then unmasked, then cleared
    xfer(1'b0, ACS_OFS_STATUS, 32'h0);
    chk(rdv[1:0], 2'h1);
    chk(irq, 1'b0);
    xfer(1'b1, ACS_OFS_MASK, 32'h3);
    repeat (2) @(posedge sysClk);
    chk(irq, 1'b1);
    xfer(1'b1, ACS_OFS_STATUS, 32'h3);
    repeat (2) @(posedge sysClk);
    chk(irq, 1'b0);
    // every clock and sample code, every channel
    for (int c = 0; c < 8; c++) begin
      xfer(1'b1, ACS_OFS_TIMING, 32'(((7 - c) << 4) | c));
      conv(32'((c % 5) << 4) | 32'h1, 7 - c, 32 - 4 * c);
      xfer(1'b0, ACS_OFS_RESULT, 32'h0);
      chk(rdv, {21'h0, 3'(c % 5), lvl(c % 5)});
    end
    xfer(1'b1, ACS_OFS_CTRL, 32'h50);
    xfer(1'b0, ACS_OFS_CTRL, 32'h0);
    chk(rdv[6:4], 3'h2);
    // trigger ignored on software source, honoured once on timer source
    xfer(1'b1, ACS_OFS_TIMING, 32'h7);
    xfer(1'b1, ACS_OFS_CTRL, 32'h40);
    pulse;
    repeat (8) @(posedge sysClk);
    chk(convBusyFlag, 1'b0);
    xfer(1'b1, ACS_OFS_CTRL, 32'h44);
    n = nDone;
    pulse;
    repeat (6) @(posedge sysClk);
    pulse;
    repeat (120) @(posedge sysClk);
    chk(nDone - n, 1);
    xfer(1'b0, ACS_OFS_RESULT, 32'h0);
    chk(rdv, {21'h0, 3'h4, lvl(4)});
    // continuous run with a channel change, then stop
    xfer(1'b1, ACS_OFS_CTRL, 32'h10);
    xfer(1'b1, ACS_OFS_STATUS, 32'h3);
    xfer(1'b1, ACS_OFS_CTRL, 32'h13);
    wait_done(1);
    xfer(1'b0, ACS_OFS_CTRL, 32'h0);
    chk(rdv[1:0], 2'h2);
    chk(convBusyFlag, 1'b1);
    xfer(1'b1, ACS_OFS_CTRL, 32'h32);
    wait_done(2);
    xfer(1'b0, ACS_OFS_RESULT, 32'h0);
    chk(rdv, {21'h0, 3'h3, lvl(3)});
    xfer(1'b0, ACS_OFS_STATUS, 32'h0);
    chk(rdv[1:0], 2'h3);
    xfer(1'b1, ACS_OFS_CTRL, 32'h30);
    while (convBusyFlag === 1'b1) @(posedge sysClk);
    repeat (4) @(posedge sysClk);
    n = nDone;
    repeat (100) @(posedge sysClk);
    chk(nDone - n, 0);
    // unmapped place reads zero
    xfer(1'b1, 8'h18, 32'hffffffff);
    xfer(1'b0, 8'h18, 32'h0);
    chk(rdv, 32'h0);
    end_sim();
  end
endmodule // acs_sequencer_tb
